// file: filter_regs_cfg.svh
`ifndef FILTER_REGS_CFG_SVH
`define FILTER_REGS_CFG_SVH
// register indices; byte address is four times the index
`define IDX_MSB 5
`define IDX_FILTER_SELECT 6'h11
`define IDX_SEP_A_LOW 6'h12
`define IDX_SEP_A_HIGH 6'h13
`define IDX_SEP_B_LOW 6'h14
`define IDX_SEP_B_HIGH 6'h15
`define IDX_EQ_A_LOW 6'h16
`define IDX_EQ_A_HIGH 6'h17
`define IDX_EQ_B_LOW 6'h18
`define IDX_EQ_B_HIGH 6'h19
`define IDX_EQ_C_LOW 6'h1a
`define IDX_EQ_C_HIGH 6'h1b
`define IDX_WIND_A_LOW 6'h1c
`define IDX_WIND_A_HIGH 6'h1d
`define IDX_WIND_B_LOW 6'h1e
`define IDX_WIND_B_HIGH 6'h1f
`define IDX_POWER 6'h20
`define IDX_MODE5 6'h21
`define IDX_LINE_MIX 6'h22
`define IDX_HP_MIX 6'h23
`define IDX_FIRST `IDX_FILTER_SELECT
`define IDX_LAST `IDX_HP_MIX
`define NUM_REGS 19
`define REG_RESET 8'h00
// writable bits; the rest are fixed zero
`define MASK_FILTER_SELECT 8'hdc
`define MASK_HIGH_TYPE 8'hbf
`define MASK_LOW6 8'h3f
`define MASK_HP_MIX 8'h7f
`define MASK_FULL 8'hff
// field positions
`define BIT_SEP_EN 2
`define BIT_EQ_EN 3
`define BIT_WIND_EN 4
`define BIT_TYPE 7
`define BIT_LINE_DIFF 0
`define BIT_STEREO_MIX 1
`define BIT_MONO_REC 2
`define BIT_IN4_DIFF 3
`define BIT_MIC_L 4
`define BIT_MIC_R 5
// bus encodings
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0
`endif

// file: filter_regs_pkg.sv
`include "filter_regs_cfg.svh"
package filter_regs_pkg;
  typedef logic [7:0] byte_reg_t;
  typedef byte_reg_t [`NUM_REGS-1:0] reg_array_t;
  typedef logic [`IDX_MSB:0] reg_idx_t;

  typedef struct packed {
    logic [1:0] gain_select;
    logic sep_mute;
    logic [13:0] sep_coef_a;
    logic [13:0] sep_coef_b;
    logic sep_lowpass;
    logic eq_bypass;
    logic [15:0] eq_coef_a;
    logic [13:0] eq_coef_b;
    logic [15:0] eq_coef_c;
    logic wind_bypass;
    logic [13:0] wind_coef_a;
    logic [13:0] wind_coef_b;
    logic wind_lowpass;
    logic [7:0] power_up;
    logic [5:0] mode;
    logic [7:0] line_mix;
    logic [6:0] hp_mix;
  } ctrl_out_t;

  typedef struct packed {
    reg_array_t regs;
    ctrl_out_t outs;
  } bank_state_t;

  typedef struct packed {
    logic wr_pend;
    reg_idx_t wr_idx;
    logic [31:0] rdata;
    logic ready;
  } port_state_t;

  function automatic logic in_map(input reg_idx_t idx);
    in_map = (idx >= `IDX_FIRST) && (idx <= `IDX_LAST);
  endfunction : in_map

  function automatic logic [4:0] slot(input reg_idx_t idx);
    slot = 5'(idx - `IDX_FIRST);
  endfunction : slot
endpackage : filter_regs_pkg

// file: reg_access_if.sv
interface reg_access_if;
  import filter_regs_pkg::*;
  logic wr_en;
  reg_idx_t wr_idx;
  logic [7:0] wr_data;
  logic rd_valid;
  reg_idx_t rd_idx;
  logic [7:0] rd_data;
  modport port (output wr_en, wr_idx, wr_data, rd_valid, rd_idx,
    input rd_data);
  modport bank (input wr_en, wr_idx, wr_data, rd_valid, rd_idx,
    output rd_data);
endinterface : reg_access_if

// file: ahb_reg_port.sv
`include "filter_regs_cfg.svh"
module ahb_reg_port
  import filter_regs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  reg_access_if.port acc // register side
);
  port_state_t st_reg, st_next;
  logic take;
  logic mapped;

  // ----------------------------------------
  // address phase decode
  // ----------------------------------------
  // non-word or unmapped access: write dropped, read returns zero
  assign take = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0)
    && (hsize == `HSIZE_WORD) && in_map(haddr[7:2]);
  assign acc.rd_idx = haddr[7:2];
  assign acc.rd_valid = take && !hwrite && mapped;
  // write lands in the data phase, when hwdata stands
  assign acc.wr_en = st_reg.wr_pend;
  assign acc.wr_idx = st_reg.wr_idx;
  assign acc.wr_data = hwdata[7:0];

  // next state: zero wait states, read data from the bank's next view
  always_comb begin
    st_next = st_reg;
    st_next.wr_pend = take && hwrite && mapped;
    st_next.wr_idx = haddr[7:2];
    st_next.rdata = acc.rd_valid ? {24'h000000, acc.rd_data} : 32'h0;
    st_next.ready = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp = `HRESP_OKAY;
endmodule : ahb_reg_port

// file: filter_coeff_and_routing_regs.sv
// Function
// - separation off mutes, on applies coefficients
// - equalizer off passes through at unity
// - wind filter off passes through at unity
// - two 14-bit separation coefficients, low first
// - separation type bit: high-pass or low-pass
// - equalizer coefficients 16, 14, 16 bits
// - two 14-bit wind coefficients, low first
// - wind type bit: high-pass or low-pass
// - eight power-up bits, all off at reset
// - mode bit 0 selects differential line out
// - mode bit 2 selects mono recording
// - mode bit 3 selects differential input four
// - mode bits 4,5 route mic to outputs
// - line mix: six switches plus mono bits
// - headphone mix: six switches, mono, bit7 zero
// - two-bit gain select, reset zero
`include "filter_regs_cfg.svh"
module filter_coeff_and_routing_regs
  import filter_regs_pkg::*;
(
  input wire logic CLK_SYS, // 200 MHz system clock
  input wire logic RST_N, // sync reset, active low
  input wire logic HSEL, // slave select
  input wire logic [31:0] HADDR, // byte address
  input wire logic [1:0] HTRANS, // transfer type
  input wire logic HWRITE, // write when high
  input wire logic [2:0] HSIZE, // transfer size
  input wire logic [31:0] HWDATA, // write data
  input wire logic HREADY, // bus ready
  output logic [31:0] HRDATA, // read data
  output logic HREADYOUT, // slave ready
  output logic HRESP, // response
  output logic [1:0] GAIN_BLOCK_SELECT, // gain block select
  output logic SEPARATION_MUTE, // separation path muted
  output logic [13:0] SEPARATION_COEF_A, // applied coef a
  output logic [13:0] SEPARATION_COEF_B, // applied coef b
  output logic SEPARATION_FILTER_TYPE, // 1 low-pass
  output logic EQUALIZER_BYPASS, // unity pass-through
  output logic [15:0] EQUALIZER_COEF_A, // applied coef a
  output logic [13:0] EQUALIZER_COEF_B, // applied coef b
  output logic [15:0] EQUALIZER_COEF_C, // applied coef c
  output logic WIND_BYPASS, // unity pass-through
  output logic [13:0] WIND_COEF_A, // applied coef a
  output logic [13:0] WIND_COEF_B, // applied coef b
  output logic WIND_FILTER_TYPE, // 1 low-pass
  output logic [7:0] ANALOG_POWER_UP, // power bits
  output logic LINE_OUT_DIFFERENTIAL, // mono diff out
  output logic STEREO_MIX_INPUT_SELECT, // stereo pair 3
  output logic PLL_BLOCKED, // PLL must stay unused
  output logic MONO_RECORD, // (L+R)/2 both sides
  output logic INPUT4_DIFFERENTIAL, // mono diff input 4
  output logic LEFT_MIC_TO_OUTPUT_ROUTE, // mic-amp left
  output logic RIGHT_MIC_TO_OUTPUT_ROUTE, // mic-amp right
  output logic [7:0] LINE_OUT_MIX_SWITCHES, // line mixer
  output logic [6:0] HP_MIX_SWITCHES // headphone mixer
);
  // ----------------------------------------
  // bus front end
  // ----------------------------------------
  reg_access_if acc_if ();

  ahb_reg_port u_port (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hrdata(HRDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .acc(acc_if.port)
  );

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  bank_state_t st_reg, st_next;

  // writable bits per register; the remainder stays zero
  function automatic byte_reg_t reg_mask(input reg_idx_t idx);
    case (idx)
      `IDX_FILTER_SELECT: reg_mask = `MASK_FILTER_SELECT;
      `IDX_SEP_A_HIGH, `IDX_WIND_A_HIGH: reg_mask = `MASK_HIGH_TYPE;
      `IDX_SEP_B_HIGH, `IDX_EQ_B_HIGH, `IDX_WIND_B_HIGH,
      `IDX_MODE5: reg_mask = `MASK_LOW6;
      `IDX_HP_MIX: reg_mask = `MASK_HP_MIX;
      default: reg_mask = in_map(idx) ? `MASK_FULL : 8'h00;
    endcase
  endfunction : reg_mask

  // out-of-map index reads zero instead of indexing past the array
  function automatic byte_reg_t reg_at(input reg_array_t r,
    input reg_idx_t idx);
    reg_at = in_map(idx) ? r[slot(idx)] : 8'h00;
  endfunction : reg_at

  // writes, then control outputs from the updated view
  always_comb begin
    reg_array_t r;
    logic sep_en;
    logic eq_en;
    logic wind_en;
    r = st_reg.regs;
    sep_en = 1'b0;
    eq_en = 1'b0;
    wind_en = 1'b0;
    st_next = st_reg;
    for (int i = 0; i < `NUM_REGS; i++) begin
      if (acc_if.wr_en && acc_if.wr_idx == 6'(`IDX_FIRST + i)) begin
        r[i] = acc_if.wr_data & reg_mask(acc_if.wr_idx);
      end
    end
    st_next.regs = r;
    sep_en = r[slot(`IDX_FILTER_SELECT)][`BIT_SEP_EN];
    eq_en = r[slot(`IDX_FILTER_SELECT)][`BIT_EQ_EN];
    wind_en = r[slot(`IDX_FILTER_SELECT)][`BIT_WIND_EN];
    st_next.outs.gain_select = r[slot(`IDX_FILTER_SELECT)][7:6];
    // disabled separation feeds silence downstream
    st_next.outs.sep_mute = !sep_en;
    st_next.outs.sep_coef_a = sep_en ?
      {r[slot(`IDX_SEP_A_HIGH)][5:0], r[slot(`IDX_SEP_A_LOW)]} :
      14'h0000;
    st_next.outs.sep_coef_b = sep_en ?
      {r[slot(`IDX_SEP_B_HIGH)][5:0], r[slot(`IDX_SEP_B_LOW)]} :
      14'h0000;
    st_next.outs.sep_lowpass = r[slot(`IDX_SEP_A_HIGH)][`BIT_TYPE];
    // zero coefficients while bypassed keep the arithmetic idle
    st_next.outs.eq_bypass = !eq_en;
    st_next.outs.eq_coef_a = eq_en ?
      {r[slot(`IDX_EQ_A_HIGH)], r[slot(`IDX_EQ_A_LOW)]} :
      16'h0000;
    st_next.outs.eq_coef_b = eq_en ?
      {r[slot(`IDX_EQ_B_HIGH)][5:0], r[slot(`IDX_EQ_B_LOW)]} :
      14'h0000;
    st_next.outs.eq_coef_c = eq_en ?
      {r[slot(`IDX_EQ_C_HIGH)], r[slot(`IDX_EQ_C_LOW)]} :
      16'h0000;
    st_next.outs.wind_bypass = !wind_en;
    st_next.outs.wind_coef_a = wind_en ?
      {r[slot(`IDX_WIND_A_HIGH)][5:0], r[slot(`IDX_WIND_A_LOW)]} :
      14'h0000;
    st_next.outs.wind_coef_b = wind_en ?
      {r[slot(`IDX_WIND_B_HIGH)][5:0], r[slot(`IDX_WIND_B_LOW)]} :
      14'h0000;
    st_next.outs.wind_lowpass = r[slot(`IDX_WIND_A_HIGH)][`BIT_TYPE];
    st_next.outs.power_up = r[slot(`IDX_POWER)];
    st_next.outs.mode = r[slot(`IDX_MODE5)][5:0];
    st_next.outs.line_mix = r[slot(`IDX_LINE_MIX)];
    st_next.outs.hp_mix = r[slot(`IDX_HP_MIX)][6:0];
    // read sees a write landing this same cycle
    acc_if.rd_data = reg_at(r, acc_if.rd_idx);
  end

  // reset: registers zero, so every filter starts muted or bypassed
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      st_reg.regs <= {`NUM_REGS{`REG_RESET}};
      st_reg.outs <= '0;
      st_reg.outs.sep_mute <= 1'b1;
      st_reg.outs.eq_bypass <= 1'b1;
      st_reg.outs.wind_bypass <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs, straight from the state flops
  // ----------------------------------------
  assign GAIN_BLOCK_SELECT = st_reg.outs.gain_select;
  assign SEPARATION_MUTE = st_reg.outs.sep_mute;
  assign SEPARATION_COEF_A = st_reg.outs.sep_coef_a;
  assign SEPARATION_COEF_B = st_reg.outs.sep_coef_b;
  assign SEPARATION_FILTER_TYPE = st_reg.outs.sep_lowpass;
  assign EQUALIZER_BYPASS = st_reg.outs.eq_bypass;
  assign EQUALIZER_COEF_A = st_reg.outs.eq_coef_a;
  assign EQUALIZER_COEF_B = st_reg.outs.eq_coef_b;
  assign EQUALIZER_COEF_C = st_reg.outs.eq_coef_c;
  assign WIND_BYPASS = st_reg.outs.wind_bypass;
  assign WIND_COEF_A = st_reg.outs.wind_coef_a;
  assign WIND_COEF_B = st_reg.outs.wind_coef_b;
  assign WIND_FILTER_TYPE = st_reg.outs.wind_lowpass;
  assign ANALOG_POWER_UP = st_reg.outs.power_up;
  // mode bits
  assign LINE_OUT_DIFFERENTIAL = st_reg.outs.mode[`BIT_LINE_DIFF];
  assign STEREO_MIX_INPUT_SELECT = st_reg.outs.mode[`BIT_STEREO_MIX];
  // flag only; clocking logic elsewhere must keep the PLL off
  assign PLL_BLOCKED = st_reg.outs.mode[`BIT_STEREO_MIX];
  assign MONO_RECORD = st_reg.outs.mode[`BIT_MONO_REC];
  assign INPUT4_DIFFERENTIAL = st_reg.outs.mode[`BIT_IN4_DIFF];
  assign LEFT_MIC_TO_OUTPUT_ROUTE = st_reg.outs.mode[`BIT_MIC_L];
  assign RIGHT_MIC_TO_OUTPUT_ROUTE = st_reg.outs.mode[`BIT_MIC_R];
  assign LINE_OUT_MIX_SWITCHES = st_reg.outs.line_mix;
  assign HP_MIX_SWITCHES = st_reg.outs.hp_mix;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  logic wr_fsel;
  logic wr_mode;
  assign wr_fsel = acc_if.wr_en && acc_if.wr_idx == `IDX_FILTER_SELECT;
  assign wr_mode = acc_if.wr_en && acc_if.wr_idx == `IDX_MODE5;

  // enables: each path follows its bit one edge after the write
  sep_mute_a: assert property (wr_fsel |=>
    SEPARATION_MUTE == !$past(acc_if.wr_data[`BIT_SEP_EN]))
    else $error("separation mute does not follow enable write");

  // gated coefficients keep disabled paths silent or transparent
  sep_silent_a: assert property (SEPARATION_MUTE |->
    SEPARATION_COEF_A == 14'h0000 && SEPARATION_COEF_B == 14'h0000)
    else $error("muted separation path carries coefficients");

  eq_through_a: assert property (EQUALIZER_BYPASS |->
    EQUALIZER_COEF_A == 16'h0000 && EQUALIZER_COEF_B == 14'h0000
    && EQUALIZER_COEF_C == 16'h0000)
    else $error("bypassed equalizer carries coefficients");

  eq_enable_a: assert property (wr_fsel |=>
    EQUALIZER_BYPASS == !$past(acc_if.wr_data[`BIT_EQ_EN]))
    else $error("equalizer bypass does not follow enable write");

  wind_enable_a: assert property (wr_fsel |=>
    WIND_BYPASS == !$past(acc_if.wr_data[`BIT_WIND_EN])
    && (WIND_BYPASS || WIND_COEF_A == {
      st_reg.regs[slot(`IDX_WIND_A_HIGH)][5:0],
      st_reg.regs[slot(`IDX_WIND_A_LOW)]}))
    else $error("wind filter enable not applied");

  // packing: high bits come from the low six of the next byte
  sep_pack_a: assert property (!SEPARATION_MUTE |->
    SEPARATION_COEF_B == {st_reg.regs[slot(`IDX_SEP_B_HIGH)][5:0],
    st_reg.regs[slot(`IDX_SEP_B_LOW)]})
    else $error("separation coefficient b packed wrongly");

  // type bits are not gated, so a filter can be set up while off
  sep_type_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_SEP_A_HIGH |=>
    SEPARATION_FILTER_TYPE == $past(acc_if.wr_data[`BIT_TYPE]))
    else $error("separation type bit not taken");

  eq_pack_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_EQ_C_HIGH && !EQUALIZER_BYPASS
    && !wr_fsel |=>
    EQUALIZER_COEF_C[15:8] == $past(acc_if.wr_data))
    else $error("equalizer coefficient c high byte lost");

  wind_pack_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_WIND_B_HIGH && !WIND_BYPASS
    && !wr_fsel |=>
    WIND_COEF_B[13:8] == $past(acc_if.wr_data[5:0]))
    else $error("wind coefficient b high bits lost");

  wind_type_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_WIND_A_HIGH |=>
    WIND_FILTER_TYPE == $past(acc_if.wr_data[`BIT_TYPE]))
    else $error("wind type bit not taken");

  // power bits must not drift between writes
  power_bits_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_POWER |=>
    ANALOG_POWER_UP == $past(acc_if.wr_data) ##1
    ($stable(ANALOG_POWER_UP) || $past(acc_if.wr_en)))
    else $error("power bits wrong after write");

  // mode register fields, one output per bit except bit 1, which drives two
  mode_bits_a: assert property (wr_mode |=>
    LINE_OUT_DIFFERENTIAL == $past(acc_if.wr_data[`BIT_LINE_DIFF])
    && MONO_RECORD == $past(acc_if.wr_data[`BIT_MONO_REC])
    && INPUT4_DIFFERENTIAL == $past(acc_if.wr_data[`BIT_IN4_DIFF]))
    else $error("mode bits not applied");

  // flag only: software keeps the PLL idle while it stands
  pll_flag_a: assert property (wr_mode |=>
    PLL_BLOCKED == $past(acc_if.wr_data[`BIT_STEREO_MIX])
    && PLL_BLOCKED == STEREO_MIX_INPUT_SELECT)
    else $error("stereo mix flag does not block PLL");

  mic_route_a: assert property (wr_mode |=>
    {RIGHT_MIC_TO_OUTPUT_ROUTE, LEFT_MIC_TO_OUTPUT_ROUTE}
    == $past(acc_if.wr_data[`BIT_MIC_R:`BIT_MIC_L]))
    else $error("mic routing bits not applied");

  // mixer switches: line side on write, headphone side on readback
  line_mix_a: assert property (acc_if.wr_en
    && acc_if.wr_idx == `IDX_LINE_MIX |=>
    LINE_OUT_MIX_SWITCHES == $past(acc_if.wr_data))
    else $error("line mixer switches not applied");

  hp_mix_a: assert property (acc_if.rd_valid
    && acc_if.rd_idx == `IDX_HP_MIX |=>
    HRDATA[7] == 1'b0 && HRDATA[6:0] == HP_MIX_SWITCHES)
    else $error("headphone mixer readback wrong");

  // gain field shares the enable byte
  gain_sel_a: assert property (wr_fsel |=>
    GAIN_BLOCK_SELECT == $past(acc_if.wr_data[7:6]))
    else $error("gain select not applied");

  // unused bits read zero; written bits read back unchanged
  fixed_zero_a: assert property (acc_if.rd_valid |=>
    HRDATA[31:8] == 24'h000000
    && (HRDATA[7:0] & ~reg_mask($past(acc_if.rd_idx))) == 8'h00)
    else $error("fixed zero bit reads as one");

  hold_value_a: assert property (!acc_if.wr_en |=>
    st_reg.regs == $past(st_reg.regs))
    else $error("register changed without a write");

  readback_a: assert property (acc_if.wr_en ##1
    (acc_if.rd_valid && acc_if.rd_idx == $past(acc_if.wr_idx)) |=>
    HRDATA[7:0] == ($past(acc_if.wr_data, 2)
    & reg_mask($past(acc_if.rd_idx))))
    else $error("readback differs from value written");

  // zero wait states: a stalled bus would hang the host
  okay_ready_a: assert property (HREADYOUT && HRESP == `HRESP_OKAY)
    else $error("slave stalled or answered an error");

  // first edge out of reset: filters off, analog paths powered down
  reset_state_a: assert property ($rose(RST_N) |->
    SEPARATION_MUTE && EQUALIZER_BYPASS && WIND_BYPASS
    && ANALOG_POWER_UP == 8'h00 && GAIN_BLOCK_SELECT == 2'h0
    && LINE_OUT_MIX_SWITCHES == 8'h00 && HP_MIX_SWITCHES == 7'h00)
    else $error("control outputs not cleared by reset");

  // main scenarios the bench is expected to reach
  sep_on_c: cover property (wr_fsel ##1 !SEPARATION_MUTE);
  wr_rd_c: cover property (acc_if.wr_en ##1 acc_if.rd_valid);
  pll_block_c: cover property (wr_mode ##1 PLL_BLOCKED);
  eq_on_c: cover property (!EQUALIZER_BYPASS && EQUALIZER_COEF_C != 0);
  mono_rec_c: cover property (wr_mode ##1 MONO_RECORD);
endmodule : filter_coeff_and_routing_regs

// file: filter_coeff_and_routing_regs_tb.sv
module filter_coeff_and_routing_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam int CYCLE_LIMIT = 20000;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'h2;
  logic [31:0] HWDATA = 32'h0;
  wire logic HREADY;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, SEPARATION_MUTE, SEPARATION_FILTER_TYPE;
  logic [1:0] GAIN_BLOCK_SELECT;
  logic [13:0] SEPARATION_COEF_A, SEPARATION_COEF_B, EQUALIZER_COEF_B;
  logic [13:0] WIND_COEF_A, WIND_COEF_B;
  logic [15:0] EQUALIZER_COEF_A, EQUALIZER_COEF_C;
  logic EQUALIZER_BYPASS, WIND_BYPASS, WIND_FILTER_TYPE, PLL_BLOCKED;
  logic [7:0] ANALOG_POWER_UP, LINE_OUT_MIX_SWITCHES;
  logic LINE_OUT_DIFFERENTIAL, STEREO_MIX_INPUT_SELECT, MONO_RECORD;
  logic INPUT4_DIFFERENTIAL, LEFT_MIC_TO_OUTPUT_ROUTE;
  logic RIGHT_MIC_TO_OUTPUT_ROUTE;
  logic [6:0] HP_MIX_SWITCHES;
  int err_total = 0;
  int check_count = 0;
  int cycle_count = 0;
  logic [7:0] shadow [0:18];
  logic [31:0] bad_addr [0:4] = '{32'h49, 32'h48, 32'h90, 32'h40, 32'h148};
  logic [2:0] bad_size [0:4] = '{3'h2, 3'h0, 3'h2, 3'h2, 3'h2};
  logic [31:0] rd_val;

  // single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  always #2.5 CLK_SYS = ~CLK_SYS;

  filter_coeff_and_routing_regs filter_coeff_and_routing_regs_inst (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .GAIN_BLOCK_SELECT(GAIN_BLOCK_SELECT),
    .SEPARATION_MUTE(SEPARATION_MUTE),
    .SEPARATION_COEF_A(SEPARATION_COEF_A),
    .SEPARATION_COEF_B(SEPARATION_COEF_B),
    .SEPARATION_FILTER_TYPE(SEPARATION_FILTER_TYPE),
    .EQUALIZER_BYPASS(EQUALIZER_BYPASS),
    .EQUALIZER_COEF_A(EQUALIZER_COEF_A),
    .EQUALIZER_COEF_B(EQUALIZER_COEF_B),
    .EQUALIZER_COEF_C(EQUALIZER_COEF_C), .WIND_BYPASS(WIND_BYPASS),
    .WIND_COEF_A(WIND_COEF_A), .WIND_COEF_B(WIND_COEF_B),
    .WIND_FILTER_TYPE(WIND_FILTER_TYPE),
    .ANALOG_POWER_UP(ANALOG_POWER_UP),
    .LINE_OUT_DIFFERENTIAL(LINE_OUT_DIFFERENTIAL),
    .STEREO_MIX_INPUT_SELECT(STEREO_MIX_INPUT_SELECT),
    .PLL_BLOCKED(PLL_BLOCKED), .MONO_RECORD(MONO_RECORD),
    .INPUT4_DIFFERENTIAL(INPUT4_DIFFERENTIAL),
    .LEFT_MIC_TO_OUTPUT_ROUTE(LEFT_MIC_TO_OUTPUT_ROUTE),
    .RIGHT_MIC_TO_OUTPUT_ROUTE(RIGHT_MIC_TO_OUTPUT_ROUTE),
    .LINE_OUT_MIX_SWITCHES(LINE_OUT_MIX_SWITCHES),
    .HP_MIX_SWITCHES(HP_MIX_SWITCHES)
  );

  // ----------------------------------------
  // expectations and comparisons
  // ----------------------------------------
  // writable bits of each register; all others are fixed zero
  function automatic logic [7:0] mask(input logic [5:0] idx);
    case (idx)
      6'h11: mask = 8'hdc;
      6'h13, 6'h1d: mask = 8'hbf;
      6'h15, 6'h19, 6'h1f, 6'h21: mask = 8'h3f;
      6'h23: mask = 8'h7f;
      default: mask = 8'hff;
    endcase
  endfunction : mask

  function automatic logic [13:0] c14(input logic [7:0] hi, lo);
    c14 = {hi[5:0], lo};
  endfunction : c14

  task automatic check_reg(input logic [5:0] idx, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR reg 0x%0h expected 0x%0h seen 0x%0h", idx, exp, got);
    end
  endtask : check_reg

  task automatic check_out(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected 0x%0h seen 0x%0h", name, exp, got);
    end
  endtask : check_out

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // bus master and register access
  // ----------------------------------------
  // one transfer, called just after an edge; ends at the edge that
  // closes its data phase, so calls follow each other with no gap
  task automatic bus_xfer(input logic wr, input logic [31:0] addr,
      input logic [2:0] size, input logic [7:0] wd, output logic [31:0] rd);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= addr;
    HSIZE <= size;
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
    check_out("hresp", 32'h0, {31'h0, HRESP});
  endtask : bus_xfer

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus_xfer(1'b1, {24'h0, idx, 2'b00}, 3'h2, d, unused);
    shadow[idx - 6'h11] = d & mask(idx);
  endtask : wr_reg

  task automatic check_all();
    logic [31:0] v;
    for (int i = 0; i < 19; i++) begin
      bus_xfer(1'b0, {24'h0, 6'(6'h11 + i), 2'b00}, 3'h2, 8'h00, v);
      check_reg(6'(6'h11 + i), {24'h0, shadow[i]}, v);
    end
  endtask : check_all

  // control outputs follow the register image once the write edge lands
  task automatic check_outs();
    logic se, qe, we;
    #1;
    se = shadow[0][2];
    qe = shadow[0][3];
    we = shadow[0][4];
    check_out("separation", {~se, shadow[2][7],
      {14{se}} & c14(shadow[4], shadow[3]),
      {14{se}} & c14(shadow[2], shadow[1])},
      {SEPARATION_MUTE, SEPARATION_FILTER_TYPE, SEPARATION_COEF_B,
      SEPARATION_COEF_A});
    check_out("eq_ab", {~qe, {14{qe}} & c14(shadow[8], shadow[7]),
      {16{qe}} & {shadow[6], shadow[5]}},
      {EQUALIZER_BYPASS, EQUALIZER_COEF_B, EQUALIZER_COEF_A});
    check_out("eq_c", {16{qe}} & {shadow[10], shadow[9]},
      EQUALIZER_COEF_C);
    check_out("wind", {~we, shadow[12][7],
      {14{we}} & c14(shadow[14], shadow[13]),
      {14{we}} & c14(shadow[12], shadow[11])},
      {WIND_BYPASS, WIND_FILTER_TYPE, WIND_COEF_B, WIND_COEF_A});
    check_out("mix", {shadow[0][7:6], shadow[15],
      shadow[17], shadow[18][6:0]},
      {GAIN_BLOCK_SELECT, ANALOG_POWER_UP, LINE_OUT_MIX_SWITCHES,
      HP_MIX_SWITCHES});
    check_out("mode", {shadow[16][1], shadow[16][5:0]},
      {PLL_BLOCKED, RIGHT_MIC_TO_OUTPUT_ROUTE, LEFT_MIC_TO_OUTPUT_ROUTE,
      INPUT4_DIFFERENTIAL, MONO_RECORD, STEREO_MIX_INPUT_SELECT,
      LINE_OUT_DIFFERENTIAL});
    @(posedge CLK_SYS); // hand back on an edge for the next transfer
  endtask : check_outs

  task automatic do_reset();
    @(posedge CLK_SYS);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
  endtask : do_reset

  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  // a stuck ready would otherwise hang the bus tasks forever
  always @(posedge CLK_SYS) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == CYCLE_LIMIT) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    do_reset();
    check_outs();
    check_all();
    for (int i = 0; i < 19; i++) wr_reg(6'(6'h11 + i), 8'hff);
    check_all();
    check_outs();
    for (int i = 0; i < 19; i++) wr_reg(6'(6'h11 + i), 8'(8'h5b + i * 39));
    check_all();
    check_outs();
    // each enable alone under every gain code
    for (int g = 0; g < 4; g++) begin
      for (int b = 2; b < 5; b++) begin
        wr_reg(6'h11, {2'(g), 6'h01 << b});
        check_outs();
      end
    end
    // walking one through power, mode and mixer registers
    for (int r = 0; r < 4; r++) begin
      for (int b = 0; b < 8; b++) begin
        wr_reg(6'(6'h20 + r), 8'h01 << b);
        check_outs();
      end
    end
    // read in the cycle straight after a write to the same register
    wr_reg(6'h13, 8'hff);
    bus_xfer(1'b0, 32'h4c, 3'h2, 8'h00, rd_val);
    check_reg(6'h13, {24'h0, shadow[2]}, rd_val);
    // misaligned, narrow and unmapped accesses are dropped and read zero
    for (int k = 0; k < 5; k++) begin
      bus_xfer(1'b1, bad_addr[k], bad_size[k], 8'hff, rd_val);
      bus_xfer(1'b0, bad_addr[k], bad_size[k], 8'h00, rd_val);
      check_reg(bad_addr[k][7:2], 32'h0, rd_val);
    end
    check_all();
    do_reset();
    check_outs();
    check_all();
    finish_test();
  end
endmodule : filter_coeff_and_routing_regs_tb
